/* common/luart_regs.vh */
/*
 holds register offsets, field positions, reset values and break timing
 counts for the break sequencing serial unit.
 assumes inclusion by bare name from the design files.
*/
// Contract
// [R1] The serial unit's base clock is a divided system clock and must not be the internal oscillator.
// [R2] Software changes the base clock select field only while the unit power enable bit is 0.
// [R3] Software rewrites the baud divisor only while transmit and receive enable are both cleared.
// [R4] One bit period equals two output periods of the 8-bit divisor counter.
// [R5] A same-value rewrite of the control register during traffic restarts the break operation.
// [R6] After a break reception error the error flag stays 1 until software returns to break mode; the code holds it until a status write-one clear.
// [R7] Software sets the break receive trigger only while power enable and receive enable are 1.
// [R8] The break receive trigger reads as 0 and clears itself after a correct break reception.
// [R9] Software sets the break transmit trigger only while power enable and transmit enable are 1.
// [R10] The break transmit trigger reads as 0 and clears itself when break transmission ends.
// [R11] Software clears transmit and receive enable before changing bit order or output level.
// [R12] Stop mode is entered by clearing transmit and receive enable, then power enable.
// [R13] To start, software sets power enable first and the transmit and receive enables after.
// [R14] For compatibility software programs break trigger and break length bits as 0,1,0,1.
// [R15] Reception should be enabled while the receive pin is high; a low pin starts reception at once.
// [R16] A break transmission holds the line low for the chosen number of bits, then idles.
`ifndef LUART_REGS_VH
`define LUART_REGS_VH
`define LUART_OFS_MODE 4'h0
`define LUART_OFS_CTRL 4'h4
`define LUART_OFS_CLKSEL 4'h8
`define LUART_OFS_BAUD 4'hc
`define LUART_OFS_STAT 4'h0
`define LUART_OFS_STAT_B 8'h10
`define LUART_OFS_MASK_B 8'h14
`define LUART_MODE_POWER 7
`define LUART_MODE_TXE 6
`define LUART_MODE_RXE 5
`define LUART_CTRL_BRT 6
`define LUART_CTRL_BTT 5
`define LUART_CTRL_BLEN_HI 4
`define LUART_CTRL_BLEN_LO 2
`define LUART_CTRL_DIR 1
`define LUART_CTRL_INV 0
`define LUART_ST_RXERR 0
`define LUART_ST_RXDONE 1
`define LUART_ST_TXDONE 2
`define LUART_ST_TXBUSY 4
`define LUART_ST_RXARM 5
`define LUART_RST_MODE 3'h0
`define LUART_RST_CTRL 5'h14
`define LUART_RST_CLKSEL 4'h0
`define LUART_RST_BAUD 8'hff
`define LUART_BRK_BASE 5'h08
`define LUART_BRK_RX_MIN 5'h0b
`define LUART_PRESC_W 11
`endif

/* verilog/luart_brg.v */
/*
 baud generator: base clock prescaler and 8-bit divisor counter whose
 output is halved into one bit-period enable pulse.
 assumes a single clock aclk; all rates are one-cycle enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luart_regs.vh"
module luart_brg #(
  parameter PW = `LUART_PRESC_W
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [3:0] clk_sel,
  input wire [7:0] divisor,
  output reg bit_tick_q
);
  reg [PW-1:0] presc_q;
  reg [7:0] cnt_q;
  reg half_q;
  wire [PW-1:0] mask;
  wire base_tick;
  wire cnt_wrap;

  // base clock is aclk divided by 2^clk_sel, or by 2^11 for any clk_sel above 10
  assign mask = (clk_sel > 4'ha) ? {PW{1'b1}} : ~({PW{1'b1}} << clk_sel);
  assign base_tick = run && ((presc_q & mask) == mask);
  assign cnt_wrap = base_tick && (cnt_q >= divisor - 8'h01);

  // prescaler, divisor counter and halving stage
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      presc_q <= {PW{1'b0}};
      cnt_q <= 8'h00;
      half_q <= 1'b0;
      bit_tick_q <= 1'b0;
    end else begin
      presc_q <= presc_q + {{(PW-1){1'b0}}, 1'b1};
      bit_tick_q <= 1'b0;
      if (base_tick) begin
        cnt_q <= cnt_wrap ? 8'h00 : cnt_q + 8'h01;
      end
      // [R4] halve counter output
      if (cnt_wrap) begin
        half_q <= ~half_q;
        bit_tick_q <= half_q;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/luart_top.v */
/*
 break-field sequencing core of the async serial unit with an AXI4-Lite
 register slave, break transmit and break receive engines and interrupt.
 assumes the receive pin is asynchronous and aclk is the only clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "luart_regs.vh"
module luart_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire receive_pin,
  output reg txd_q,
  output wire irq
);
  // register state
  reg unit_power_enable_q;
  reg transmit_enable_bit_q;
  reg receive_enable_bit_q;
  reg [2:0] break_length_q;
  reg bit_order_select_q;
  reg transmit_level_invert_q;
  reg [3:0] base_clock_select_q;
  reg [7:0] baud_divisor_field_q;
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  // axi state
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  // pin synchroniser
  reg rx_meta_q;
  reg rx_sync_q;
  // break engines
  reg tx_busy_q;
  reg [4:0] tx_cnt_q;
  reg rx_armed_q;
  reg rx_low_q;
  reg [4:0] rx_cnt_q;
  wire bit_tick;
  wire wr_fire;
  wire rd_fire;
  wire wr_ctrl;
  wire tx_start;
  wire rx_start;
  wire tx_end;
  wire rx_ok;
  wire rx_bad;
  wire [2:0] ev;
  wire [2:0] w1c;
  wire tx_run;
  wire rx_run;
  wire [4:0] tx_len;

  // word decode shared by read and write paths
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      if (a == {4'h0, `LUART_OFS_MODE}) begin
        reg_sel = 3'h1;
      end else if (a == {4'h0, `LUART_OFS_CTRL}) begin
        reg_sel = 3'h2;
      end else if (a == {4'h0, `LUART_OFS_CLKSEL}) begin
        reg_sel = 3'h3;
      end else if (a == {4'h0, `LUART_OFS_BAUD}) begin
        reg_sel = 3'h4;
      end else if (a == `LUART_OFS_STAT_B) begin
        reg_sel = 3'h5;
      end else if (a == `LUART_OFS_MASK_B) begin
        reg_sel = 3'h6;
      end else begin
        reg_sel = 3'h0;
      end
    end
  endfunction

  // write address and data may arrive in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (reg_sel(awaddr_q) == 3'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, data from flops; triggers always read as zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      case (reg_sel(s_axi_araddr))
        3'h1: s_axi_rdata[7:5] <= {unit_power_enable_q, transmit_enable_bit_q,
                                   receive_enable_bit_q};
        // [R8] [R10] triggers read zero
        3'h2: s_axi_rdata[4:0] <= {break_length_q, bit_order_select_q,
                                   transmit_level_invert_q};
        3'h3: s_axi_rdata[3:0] <= base_clock_select_q;
        3'h4: s_axi_rdata[7:0] <= baud_divisor_field_q;
        3'h5: s_axi_rdata[5:0] <= {rx_armed_q, tx_busy_q, 1'b0, stat_q};
        3'h6: s_axi_rdata[2:0] <= mask_q;
        default: s_axi_rresp <= 2'h2;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // software view of configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      {unit_power_enable_q, transmit_enable_bit_q, receive_enable_bit_q} <= `LUART_RST_MODE;
      {break_length_q, bit_order_select_q, transmit_level_invert_q} <= `LUART_RST_CTRL;
      base_clock_select_q <= `LUART_RST_CLKSEL;
      baud_divisor_field_q <= `LUART_RST_BAUD;
      mask_q <= 3'h0;
    end else if (wr_fire && wstrb_q[0]) begin
      case (reg_sel(awaddr_q))
        3'h1: begin
          unit_power_enable_q <= wdata_q[`LUART_MODE_POWER];
          transmit_enable_bit_q <= wdata_q[`LUART_MODE_TXE];
          receive_enable_bit_q <= wdata_q[`LUART_MODE_RXE];
        end
        3'h2: begin
          break_length_q <= wdata_q[`LUART_CTRL_BLEN_HI:`LUART_CTRL_BLEN_LO];
          bit_order_select_q <= wdata_q[`LUART_CTRL_DIR];
          transmit_level_invert_q <= wdata_q[`LUART_CTRL_INV];
        end
        3'h3: base_clock_select_q <= wdata_q[3:0];
        3'h4: baud_divisor_field_q <= wdata_q[7:0];
        3'h6: mask_q <= wdata_q[2:0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // [R5] control write with a trigger set starts or restarts a break
  assign wr_ctrl = wr_fire && wstrb_q[0] && (reg_sel(awaddr_q) == 3'h2);
  // [R9] transmit trigger honoured only with power and transmit enable
  assign tx_start = wr_ctrl && wdata_q[`LUART_CTRL_BTT] && tx_run;
  // [R7] receive trigger honoured only with power and receive enable
  assign rx_start = wr_ctrl && wdata_q[`LUART_CTRL_BRT] && rx_run;
  // [R12] [R13] engines run only under power enable
  assign tx_run = unit_power_enable_q && transmit_enable_bit_q;
  assign rx_run = unit_power_enable_q && receive_enable_bit_q;

  // [R1] bit clock from divided aclk only
  luart_brg u_brg (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(unit_power_enable_q),
    .clk_sel(base_clock_select_q),
    .divisor(baud_divisor_field_q),
    .bit_tick_q(bit_tick)
  );

  // two-flop synchroniser on the receive pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= receive_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // break length is a base of bits plus the length code
  assign tx_len = `LUART_BRK_BASE + {2'h0, break_length_q};
  assign tx_end = tx_busy_q && bit_tick && (tx_cnt_q >= tx_len - 5'h01);

  // [R16] break transmit holds line dominant
  always @(posedge aclk) begin
    if (!aresetn || !tx_run) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 5'h00;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 5'h00;
    end else if (tx_end) begin
      // [R10] trigger clears at break end
      tx_busy_q <= 1'b0;
    end else if (tx_busy_q && bit_tick) begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
    end
  end

  // pin level, optionally inverted
  always @(posedge aclk) begin
    if (!aresetn) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= ~tx_busy_q ^ transmit_level_invert_q;
    end
  end

  // low run ends on a high pin: long enough is good, else error
  assign rx_ok = rx_armed_q && rx_low_q && rx_sync_q && (rx_cnt_q >= `LUART_BRK_RX_MIN);
  assign rx_bad = rx_armed_q && rx_low_q && rx_sync_q && (rx_cnt_q < `LUART_BRK_RX_MIN);

  // [R15] break receive counts a low pin from the moment it is armed
  always @(posedge aclk) begin
    if (!aresetn || !rx_run) begin
      rx_armed_q <= 1'b0;
      rx_low_q <= 1'b0;
      rx_cnt_q <= 5'h00;
    end else if (rx_start) begin
      rx_armed_q <= 1'b1;
      rx_low_q <= 1'b0;
      rx_cnt_q <= 5'h00;
    end else if (rx_ok || rx_bad) begin
      // [R8] trigger clears after good break
      rx_armed_q <= 1'b0;
      rx_low_q <= 1'b0;
    end else if (rx_armed_q && !rx_sync_q) begin
      rx_low_q <= 1'b1;
      if (bit_tick && rx_cnt_q != 5'h1f) begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
    end
  end

  // sticky events, set wins over write-one clear
  assign ev = {tx_end, rx_ok, rx_bad};
  assign w1c = (wr_fire && wstrb_q[0] && reg_sel(awaddr_q) == 3'h5) ? wdata_q[2:0] : 3'h0;
  // [R6] error flag holds until cleared
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~w1c) | ev;
    end
  end

  // level interrupt from unmasked status
  assign irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

/* tb/luart_chk.sv */
/* port assertions for the break sequencing serial unit top.
 assumes one clock aclk, a divisor of 4 and base select 0 while breaks run. */
`timescale 1ns/1ps
`default_nettype none
module luart_chk #(
  parameter LO_MIN = 56
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic txd_q,
  input wire logic irq
);
  logic [7:0] lo_cnt_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // length of the current low run on the line, saturating
  always @(posedge aclk) begin
    if (!aresetn || txd_q) lo_cnt_q <= 8'h00;
    else if (lo_cnt_q != 8'hff) lo_cnt_q <= lo_cnt_q + 8'h01;
  end
  property p_ctrl_rx_trig;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04 |=> !s_axi_rdata[6];
  endproperty
  a_ctrl_rx_trig: assert property (p_ctrl_rx_trig) else $error("rx trigger read high");
  property p_ctrl_tx_trig;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04 |=> !s_axi_rdata[5];
  endproperty
  a_ctrl_tx_trig: assert property (p_ctrl_tx_trig) else $error("tx trigger read high");
  property p_tx_len;
    $rose(txd_q) |-> lo_cnt_q >= LO_MIN;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("break field too short");
  // write applied with bvalid, pin flop one edge later
  property p_tx_start;
    $fell(txd_q) |-> $past(s_axi_bvalid);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("break started without a write");
  property p_irq_sticky;
    $fell(irq) |-> $rose(s_axi_bvalid);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without a write");
  // both taken at one edge, write fires the next edge and bvalid shows after it
  property p_b_after_aw;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after_aw: assert property (p_b_after_aw) else $error("write response late");
  property p_busy_b;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy_b: assert property (p_busy_b) else $error("write accepted while answering");
  property p_r_after_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read response late");
endmodule
bind luart_top luart_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .txd_q, .irq);
`default_nettype wire

/* tb/luart_node.sv */
/* remote line node on the far side of the serial pins.
 assumes the line idles high and the bench calls brk to send a low field. */
`timescale 1ns/1ps
`default_nettype none
module luart_node (
  input wire logic aclk,
  input wire logic txd,
  output var logic rx_pin
);
  int run_q;
  int lo_q;
  initial rx_pin = 1'b1;
  // measures each low run of the transmit line
  always @(posedge aclk) begin
    if (txd) begin
      if (run_q != 0) lo_q <= run_q;
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end
  // drives a low field of n cycles, then back to idle
  task automatic brk(input int n);
    @(posedge aclk);
    rx_pin <= 1'b0;
    repeat (n) @(posedge aclk);
    rx_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/lin_uart_control_sequencing_bench.sv */
/* self-checking bench for the break sequencing serial unit.
 assumes the top, its checker and the line node model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module lin_uart_control_sequencing_bench;
  logic aclk, aresetn, receive_pin, txd_q, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors, total_checks, i;
  logic [31:0] rst_v [6] = '{32'h0, 32'h14, 32'h0, 32'hff, 32'h0, 32'h0};
  luart_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .receive_pin, .txd_q, .irq);
  luart_node node (.aclk, .txd(txd_q), .rx_pin(receive_pin));
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // compares and counts
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one register write, aw and w released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw, w, b;
    @(posedge aclk);
    {aw, w, b} = 3'b110;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!b) begin
      @(negedge aclk);
      b = s_axi_bvalid;
      if (b) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !b};
    end
  endtask
  // one register read compared with its expected word
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = 2'b00);
    logic v, g;
    @(posedge aclk);
    {v, g} = 2'b10;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!g) begin
      @(negedge aclk);
      g = s_axi_rvalid;
      if (g) chk(n, s_axi_rdata, e);
      if (g) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      v = v && !s_axi_arready;
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready} <= {v, !g};
    end
  endtask
  // waits for a break field to start and end
  task automatic wait_tx;
    int k;
    for (k = 0; k < 400 && txd_q !== 1'b0; k++) @(posedge aclk);
    for (k = 0; k < 400 && txd_q !== 1'b1; k++) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) rdc("reset value", 8'(i * 4), rst_v[i]);
    rdc("unmapped read", 8'h20, 32'h0, 2'b10);
    wr(8'h20, 32'h1, 2'b10);
    $display("test reset done");
    // divided base clock, divisor, power, then enables
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h4);
    wr(8'h14, 32'h7);
    wr(8'h00, 32'h80);
    wr(8'h00, 32'he0);
    // break trigger with length code 101
    wr(8'h04, 32'h34);
    wait_tx();
    chk("tx low", 32'(node.lo_q > 96 && node.lo_q <= 106), 32'h1);
    rdc("ctrl", 8'h04, 32'h14);
    rdc("status tx", 8'h10, 32'h04);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(8'h10, 32'h4);
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(8'h04, 32'h34);
    repeat (40) @(posedge aclk);
    wr(8'h04, 32'h34);
    wait_tx();
    chk("tx refresh", 32'(node.lo_q > 136), 32'h1);
    wr(8'h10, 32'h4);
    $display("test break transmit done");
    // arm reception, transmit trigger 0 and length code 101
    wr(8'h04, 32'h54);
    rdc("rx armed", 8'h10, 32'h20);
    node.brk(96);
    repeat (24) @(posedge aclk);
    rdc("rx ok", 8'h10, 32'h02);
    rdc("ctrl rx", 8'h04, 32'h14);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h6);
    wr(8'h04, 32'h54);
    node.brk(40);
    repeat (24) @(posedge aclk);
    rdc("rx error", 8'h10, 32'h01);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'h04, 32'h54);
    rdc("error held", 8'h10, 32'h21);
    wr(8'h14, 32'h7);
    chk("irq error", {31'h0, irq}, 32'h1);
    node.brk(96);
    repeat (24) @(posedge aclk);
    rdc("rx again", 8'h10, 32'h03);
    wr(8'h10, 32'h3);
    $display("test break receive done");
    wr(8'h00, 32'h80);
    wr(8'h04, 32'h34);
    rdc("tx gated", 8'h10, 32'h00);
    chk("txd idle", {31'h0, txd_q}, 32'h1);
    // bit order and level set while both enables are clear
    wr(8'h04, 32'h17);
    @(posedge aclk);
    chk("txd inverted", {31'h0, txd_q}, 32'h0);
    rdc("ctrl levels", 8'h04, 32'h17);
    wr(8'h00, 32'h0);
    rdc("stopped", 8'h00, 32'h0);
    $display("test stop done");
    end_of_test();
  end
endmodule
`default_nettype wire
